// [frs_pkg.sv]
// package for the receive status and overhead register bank of one framer
// assumes a byte-wide processor port with a 12-bit register address
package frs_pkg;

   // ==========================================================
   // register offsets
   localparam logic [11:0] FRS_BURSTY_OFS  = 12'h062e;
   localparam logic [11:0] FRS_SEVERE_OFS  = 12'h0630;
   localparam logic [11:0] FRS_UNAVAIL_OFS = 12'h0632;
   localparam logic [11:0] FRS_TS0_OFS     = 12'h0634;
   localparam logic [11:0] FRS_TS16_OFS    = 12'h0635;
   localparam logic [11:0] FRS_STACK_OFS   = 12'h0636;
   localparam logic [11:0] FRS_SIG_OFS     = 12'h0640;

   // ==========================================================
   // sizes, positions and reset values
   localparam int          FRS_CNT_W      = 16;
   localparam int          FRS_STACK_LEN  = 10;
   localparam int          FRS_SIG_DEPTH  = 32;
   localparam int          FRS_DS1_CHANS  = 24;
   localparam logic [3:0]  FRS_PERF_BYTE0 = 4'h8;
   localparam logic [3:0]  FRS_PERF_BYTE1 = 4'h9;
   localparam logic [3:0]  FRS_LC_BYTES   = 4'h5;
   localparam logic [4:0]  FRS_CH_TS0     = 5'h00;
   localparam logic [4:0]  FRS_CH_TS16    = 5'h10;
   localparam logic [4:0]  FRS_LAST_FRAME = 5'h1f;
   localparam logic [4:0]  FRS_FIRST_FRM  = 5'h01;
   localparam logic [5:0]  FRS_LC_SYNC    = 6'h07;
   localparam logic [7:0]  FRS_BYTE_RST   = 8'h00;
   localparam logic [15:0] FRS_CNT_RST    = 16'h0000;
   localparam logic [15:0] FRS_CNT_MAX    = 16'hffff;
   localparam logic [15:0] FRS_WORD_RST   = 16'h0000;

   // ==========================================================
   // signaling channel types held in bits 6 and 5 of a DS1 register
   typedef enum logic [1:0] {
      FRS_GF_16STATE = 2'b00,
      FRS_GF_4STATE  = 2'b01,
      FRS_GF_DATA    = 2'b10,
      FRS_GF_2STATE  = 2'b11
   } frs_gf_t;

   // time slot 0 overhead of one frame pair
   typedef struct packed {
      logic       si_nfas;
      logic       si_fas;
      logic       a_bit;
      logic [4:0] sa4_to_sa8;
   } frs_ts0_t;

   // one loop-carrier data link block
   typedef struct packed {
      logic [10:0] c_bits;
      logic [3:0]  spoiler;
      logic [2:0]  m_bits;
      logic [1:0]  a_bits;
      logic [3:0]  s_bits;
   } frs_lc_t;

   // one received signaling update
   typedef struct packed {
      logic [4:0] chan;
      logic       p_bit;
      logic       e_bit;
      logic [3:0] dcba;
      frs_gf_t    tx_gf;
   } frs_sig_t;

endpackage : frs_pkg

// [frs_sig_mem.sv]
// small memory for the received signaling registers
// assumes one writer and one reader, both on clk_in
`timescale 1ns/10ps
module frs_sig_mem #(
   parameter int DEPTH = 32,
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic                     clk_in,
   input  wire logic                     rst_n_in,
   // write port
   input  wire logic                     wr_en_in,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
   input  wire logic [WIDTH-1:0]         wr_data_in,
   // read port
   input  wire logic                     rd_en_in,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
   output logic      [WIDTH-1:0]         rd_data_out
);

   // ==========================================================
   // storage
   logic [WIDTH-1:0] mem_reg [DEPTH];

   if (DEPTH < 2) begin : g_chk
      $error("frs_sig_mem needs at least two words");
   end

   // array content is not reset; the framer rewrites each word every superframe, except words 24 to 31 in DS1 mode, whose updates are dropped
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem_reg[wr_addr_in] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= '0;
      end else if (rd_en_in) begin
         rd_data_out <= mem_reg[rd_addr_in];
      end
   end

endmodule // frs_sig_mem

// [frs_regs.sv]
// receive status and overhead register bank of one framer
// assumes the framer core delivers decoded overhead with one-cycle strobes on clk_in

`timescale 1ns/10ps
module frs_regs #(
   parameter int CNT_W = frs_pkg::FRS_CNT_W
) (
   // clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rst_n_in,

   // processor register port
   input  wire logic                 cs_in,
   input  wire logic                 rd_in,
   input  wire logic                 wr_in,
   input  wire logic [11:0]          addr_in,
   input  wire logic [7:0]           wdata_in,
   output logic      [7:0]           rdata_out,
   output logic                      rd_ack_out,

   // framing mode and alignment state
   input  wire logic                 ds1_mode_in,
   input  wire logic                 crc4_on_in,
   input  wire logic                 basic_frame_align_in,
   input  wire logic                 crc4_mf_align_in,
   input  wire logic                 sig_mf_align_in,
   input  wire logic                 loss_frame_align_in,
   input  wire logic                 loss_sig_sf_align_in,
   input  wire logic                 ts0_signaling_mode_in,
   input  wire logic                 alt_cas_mode_a_in,
   input  wire logic                 alt_cas_mode_b_in,

   // one-second performance events of the remote terminal
   input  wire logic                 remote_nt_bursty_seconds_in,
   input  wire logic                 remote_nt_severe_seconds_in,
   input  wire logic                 remote_nt_unavail_seconds_in,

   // time slot 0 and 16 overhead
   input  wire logic                 ts0_valid_in,
   input  wire frs_pkg::frs_ts0_t    ts0_in,
   input  wire logic                 ts16_valid_in,
   input  wire logic [2:0]           ts16_spare_in,

   // loop-carrier data link and performance report
   input  wire logic                 lc_valid_in,
   input  wire frs_pkg::frs_lc_t     lc_in,
   input  wire logic                 perf_valid_in,
   input  wire logic [15:0]          tx_perf_report_byte_in,

   // CEPT Sa bits, one strobe per odd frame of the double multiframe
   input  wire logic                 sa_valid_in,
   input  wire logic [4:0]           sa_frame_in,
   input  wire logic [4:0]           sa_bits_in,

   // received signaling updates
   input  wire logic                 sig_valid_in,
   input  wire frs_pkg::frs_sig_t    sig_in
);

   // ==========================================================
   // parameter check
   if (CNT_W < 9 || CNT_W > 16) begin : g_chk
      $error("frs_regs counter width must lie between 9 and 16");
   end

   // ==========================================================
   // functions
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
   endfunction

   function automatic logic [7:0] cnt_byte(input logic [CNT_W-1:0] v, input logic low);
      logic [15:0] w;
      w = 16'(v);
      cnt_byte = low ? w[7:0] : w[15:8];
   endfunction

   // ==========================================================
   // performance second counters
   logic [CNT_W-1:0] bursty_reg;
   logic [CNT_W-1:0] severe_reg;
   logic [CNT_W-1:0] unavail_reg;

   // counters stick at full scale rather than wrap, so a long outage never reads small
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bursty_reg  <= CNT_W'(frs_pkg::FRS_CNT_RST);
         severe_reg  <= CNT_W'(frs_pkg::FRS_CNT_RST);
         unavail_reg <= CNT_W'(frs_pkg::FRS_CNT_RST);
      end else begin
         if (remote_nt_bursty_seconds_in) begin
            bursty_reg <= sat_inc(bursty_reg);
         end
         if (remote_nt_severe_seconds_in) begin
            severe_reg <= sat_inc(severe_reg);
         end
         if (remote_nt_unavail_seconds_in) begin
            unavail_reg <= sat_inc(unavail_reg);
         end
      end
   end

   // ==========================================================
   // time slot 0 and time slot 16 spare bits
   logic [7:0] ts0_reg;
   logic [2:0] ts16_reg;

   wire        ts0_take  = ts0_valid_in && basic_frame_align_in;
   wire        ts16_take = ts16_valid_in && sig_mf_align_in;
   wire [7:0]  ts0_next  = {ts0_in.si_nfas, ts0_in.si_fas, ts0_in.a_bit,
                            ts0_in.sa4_to_sa8};

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ts0_reg  <= frs_pkg::FRS_BYTE_RST;
         ts16_reg <= 3'h0;
      end else begin
         // out of alignment the last good value stays
         if (ts0_take) begin
            ts0_reg <= ts0_next;
         end

         if (ts16_take) begin
            ts16_reg <= ts16_spare_in;
         end
      end
   end

   // ==========================================================
   // loop-carrier data link block
   logic [39:0] lc_reg;
   logic [15:0] perf_reg;

   wire         lc_take = ds1_mode_in && lc_valid_in && !loss_frame_align_in
                          && !loss_sig_sf_align_in;
   wire [39:0]  lc_next = {2'b00, frs_pkg::FRS_LC_SYNC,
                           2'b00, frs_pkg::FRS_LC_SYNC,
                           lc_in.c_bits[10:3],
                           lc_in.c_bits[2:0], lc_in.spoiler[3:1], lc_in.m_bits[2:1],
                           lc_in.m_bits[0], lc_in.a_bits, lc_in.s_bits,
                           lc_in.spoiler[0]};

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lc_reg   <= 40'h00_0000_0000;
         perf_reg <= frs_pkg::FRS_WORD_RST;
      end else begin
         if (lc_take) begin
            lc_reg <= lc_next;
         end

         if (perf_valid_in) begin
            perf_reg <= tx_perf_report_byte_in;
         end
      end
   end

   // ==========================================================
   // CEPT Sa stack
   // bits gather in a shadow and reach the stack only at the end of a clean
   // double multiframe, so a read never mixes two multiframes
   logic [15:0] sa_shadow_reg [5];
   logic [15:0] sa_stack_reg  [5];
   logic        sa_ok_reg;

   // any alignment gap voids the whole double multiframe
   wire         sa_align   = crc4_on_in ? crc4_mf_align_in : basic_frame_align_in;
   wire [3:0]   sa_slot    = sa_frame_in[4:1];
   wire         sa_take    = !ds1_mode_in && sa_valid_in && sa_align;
   wire         sa_first   = sa_take && (sa_frame_in == frs_pkg::FRS_FIRST_FRM);
   wire         sa_commit  = sa_take && (sa_frame_in == frs_pkg::FRS_LAST_FRAME)
                             && sa_ok_reg;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sa_ok_reg <= 1'b0;
         for (int i = 0; i < 5; i++) begin
            sa_shadow_reg[i] <= frs_pkg::FRS_WORD_RST;
            sa_stack_reg[i]  <= frs_pkg::FRS_WORD_RST;
         end
      end else begin
         if (!sa_align || ds1_mode_in) begin
            sa_ok_reg <= 1'b0;
         end else if (sa_first) begin
            sa_ok_reg <= 1'b1;
         end

         if (sa_take) begin
            for (int i = 0; i < 5; i++) begin
               sa_shadow_reg[i][4'd15 - sa_slot] <= sa_bits_in[4 - i];
            end
         end
         if (sa_commit) begin
            for (int i = 0; i < 5; i++) begin
               sa_stack_reg[i] <= {sa_shadow_reg[i][15:1], sa_bits_in[4 - i]};
            end
         end
      end
   end

   // ==========================================================
   // received signaling composition
   wire       ch_ts0  = (sig_in.chan == frs_pkg::FRS_CH_TS0);
   wire       ch_ts16 = (sig_in.chan == frs_pkg::FRS_CH_TS16);
   wire       alt_cas = alt_cas_mode_a_in || alt_cas_mode_b_in;

   // the alternate modes leave bit 4 undefined; this design reads it as zero
   wire       e_keep  = ts0_signaling_mode_in && !alt_cas;
   logic [3:0] ds1_dcba;

   always_comb begin
      case (sig_in.tx_gf)
         frs_pkg::FRS_GF_16STATE: ds1_dcba = sig_in.dcba;
         frs_pkg::FRS_GF_4STATE:  ds1_dcba = {2'b00, sig_in.dcba[1:0]};
         frs_pkg::FRS_GF_2STATE:  ds1_dcba = {3'b000, sig_in.dcba[0]};
         default:                 ds1_dcba = 4'h0;
      endcase
   end

   wire [7:0] ds1_word  = {sig_in.p_bit, sig_in.tx_gf, 1'b0, ds1_dcba};
   wire [7:0] cept_word = ch_ts0  ? {3'b000, sig_in.e_bit & e_keep, 4'h0} :
                          ch_ts16 ? {3'b000, sig_in.e_bit & e_keep, 2'b00,
                                     ts0_signaling_mode_in ? sig_in.dcba[1:0] : 2'b00} :
                          {sig_in.p_bit, 2'b00, sig_in.e_bit & e_keep, sig_in.dcba};

   // DS1 has no channels 24 to 31; their updates are dropped
   wire       sig_wr    = sig_valid_in && (!ds1_mode_in ||
                          (32'(sig_in.chan) < frs_pkg::FRS_DS1_CHANS));
   wire [7:0] sig_word  = ds1_mode_in ? ds1_word : cept_word;

   // ==========================================================
   // processor read path
   // two-stage read: the signaling memory answers from a register, so every
   // register reads with the same fixed latency
   wire        rd_req  = cs_in && rd_in;
   // writes are accepted on the port and dropped; nothing here is writable
   wire        wr_drop = cs_in && wr_in && !rd_in;

   logic       rd_pend_reg;
   logic [11:0] addr_q_reg;

   logic [7:0] mem_rdata;
   logic [7:0] rd_mux;

   wire [11:0] stack_idx = addr_q_reg - frs_pkg::FRS_STACK_OFS;
   wire [11:0] sig_idx   = addr_in - frs_pkg::FRS_SIG_OFS;
   wire        sig_hit   = (addr_q_reg >= frs_pkg::FRS_SIG_OFS) &&
                           (addr_q_reg < frs_pkg::FRS_SIG_OFS + 12'(frs_pkg::FRS_SIG_DEPTH));

   logic [7:0] stack_byte;

   always_comb begin
      stack_byte = 8'h00;
      if (ds1_mode_in) begin
         if (stack_idx < 12'(frs_pkg::FRS_LC_BYTES)) begin
            stack_byte = lc_reg[8'(39 - 8 * int'(stack_idx[3:0])) -: 8];
         end else if (stack_idx[3:0] == frs_pkg::FRS_PERF_BYTE0) begin
            stack_byte = perf_reg[15:8];
         end else if (stack_idx[3:0] == frs_pkg::FRS_PERF_BYTE1) begin
            stack_byte = perf_reg[7:0];
         end
      end else if (stack_idx < 12'(frs_pkg::FRS_STACK_LEN)) begin
         stack_byte = stack_idx[0] ? sa_stack_reg[stack_idx[3:1]][7:0]
                                   : sa_stack_reg[stack_idx[3:1]][15:8];
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      case (addr_q_reg)
         frs_pkg::FRS_BURSTY_OFS:          rd_mux = cnt_byte(bursty_reg, 1'b0);
         frs_pkg::FRS_BURSTY_OFS + 12'h1:  rd_mux = cnt_byte(bursty_reg, 1'b1);
         frs_pkg::FRS_SEVERE_OFS:          rd_mux = cnt_byte(severe_reg, 1'b0);
         frs_pkg::FRS_SEVERE_OFS + 12'h1:  rd_mux = cnt_byte(severe_reg, 1'b1);
         frs_pkg::FRS_UNAVAIL_OFS:         rd_mux = cnt_byte(unavail_reg, 1'b0);
         frs_pkg::FRS_UNAVAIL_OFS + 12'h1: rd_mux = cnt_byte(unavail_reg, 1'b1);
         frs_pkg::FRS_TS0_OFS:             rd_mux = ts0_reg;
         frs_pkg::FRS_TS16_OFS:            rd_mux = {5'h00, ts16_reg};
         default: begin
            if (sig_hit) begin
               rd_mux = mem_rdata;
            end else if (addr_q_reg >= frs_pkg::FRS_STACK_OFS &&
                         addr_q_reg < frs_pkg::FRS_SIG_OFS) begin
               rd_mux = stack_byte;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_pend_reg <= 1'b0;
         addr_q_reg  <= 12'h000;
         rdata_out   <= frs_pkg::FRS_BYTE_RST;
         rd_ack_out  <= 1'b0;
      end else begin
         rd_pend_reg <= rd_req && !wr_drop;
         if (rd_req) begin
            addr_q_reg <= addr_in;
         end
         rd_ack_out  <= rd_pend_reg;
         // rdata_out holds the last answer until the next read
         if (rd_pend_reg) begin
            rdata_out <= rd_mux;
         end
      end
   end

   // ==========================================================
   // signaling register storage
   frs_sig_mem #(
      .DEPTH (frs_pkg::FRS_SIG_DEPTH),
      .WIDTH (8)
   ) u_sig_mem (
      .clk_in      (clk_in),
      .rst_n_in    (rst_n_in),
      .wr_en_in    (sig_wr),
      .wr_addr_in  (sig_in.chan),
      .wr_data_in  (sig_word),
      .rd_en_in    (rd_req),
      .rd_addr_in  (sig_idx[4:0]),
      .rd_data_out (mem_rdata)
   );

endmodule // frs_regs

// [frs_regs_asserts.sv]
// checker for the receive status and overhead register bank
// assumes it is bound into frs_regs and sees only its ports, one clock domain
`timescale 1ns/10ps
module frs_regs_asserts (
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   // register port
   input  wire logic              cs_in,
   input  wire logic              rd_in,
   input  wire logic              wr_in,
   input  wire logic [11:0]       addr_in,
   input  wire logic [7:0]        rdata_out,
   input  wire logic              rd_ack_out,
   // status inputs
   input  wire logic              ds1_mode_in,
   input  wire logic              basic_frame_align_in,
   input  wire logic              sig_mf_align_in,
   input  wire logic              ts0_valid_in,
   input  wire frs_pkg::frs_ts0_t ts0_in,
   input  wire logic              ts16_valid_in,
   input  wire logic [2:0]        ts16_spare_in,
   input  wire logic              perf_valid_in,
   input  wire logic [15:0]       tx_perf_report_byte_in
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // ==========================================================
   // read handshake
   sequence s_take;
      cs_in && rd_in;
   endsequence
   sequence s_answer;
      ##2 rd_ack_out;
   endsequence
   sequence s_ans(logic [11:0] a);
      rd_ack_out && ($past(addr_in, 2) == a);
   endsequence
   read_ack_lat_a: assert property (s_take |-> s_answer)
      else $error("read answer not two cycles after request");
   no_stray_ack_a: assert property (rd_ack_out |-> $past(cs_in && rd_in, 2))
      else $error("answer without a read");
   write_ignored_a: assert property (cs_in && wr_in && !rd_in |-> ##2 !rd_ack_out)
      else $error("write was answered");
   rdata_hold_a: assert property (!rd_ack_out |-> $stable(rdata_out))
      else $error("read data moved without an answer");
   unmapped_zero_a: assert property (
      rd_ack_out && $past(addr_in, 2) < frs_pkg::FRS_BURSTY_OFS |-> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   // ==========================================================
   // capture paths: strobe four edges before the answer, none in the next three (next two for the report byte)
   ts0_capture_a: assert property (s_ans(frs_pkg::FRS_TS0_OFS) ##0
      $past(ts0_valid_in && basic_frame_align_in, 4) && !$past(ts0_valid_in, 3)
      && !$past(ts0_valid_in, 2) && !$past(ts0_valid_in, 1)
      |-> rdata_out == $past(ts0_in, 4)) else $error("ts0 byte not captured");
   ts16_capture_a: assert property (s_ans(frs_pkg::FRS_TS16_OFS) ##0
      $past(ts16_valid_in && sig_mf_align_in, 4) && !$past(ts16_valid_in, 3)
      && !$past(ts16_valid_in, 2) && !$past(ts16_valid_in, 1)
      |-> rdata_out == {5'h00, $past(ts16_spare_in, 4)}) else $error("ts16 spares wrong");
   perf_capture_a: assert property (s_ans(12'h063e) ##0 $past(ds1_mode_in, 2)
      && $past(perf_valid_in, 4) && !$past(perf_valid_in, 3) && !$past(perf_valid_in, 2)
      |-> rdata_out == $past(tx_perf_report_byte_in[15:8], 4)) else $error("report byte wrong");
endmodule // frs_regs_asserts

// [frs_line_model.sv]
// remote line terminal: sends the Sa bits of one CRC-4 double multiframe
// assumes the pattern is laid out as the ten stack bytes, first byte in the msbs
`timescale 1ns/10ps
module frs_line_model (
   // clock and command
   input  wire logic        clk_in,
   input  wire logic        start_in,
   input  wire logic [79:0] pattern_in,
   // Sa strobes toward the framer
   output logic             busy_out,
   output logic             sa_valid_out,
   output logic [4:0]       sa_frame_out,
   output logic [4:0]       sa_bits_out
);
   initial begin
      busy_out = 1'b0;
      sa_valid_out = 1'b0;
      sa_frame_out = 5'h00;
      sa_bits_out = 5'h00;
      forever begin
         @(posedge clk_in);
         if (start_in === 1'b1) begin
            busy_out <= 1'b1;
            // odd frames 1 to 31 in order, Sa4 in the msb
            for (int j = 0; j < 16; j++) begin
               sa_valid_out <= 1'b1;
               sa_frame_out <= 5'(2 * j + 1);
               for (int k = 0; k < 5; k++) sa_bits_out[4 - k] <= pattern_in[79 - 16 * k - j];
               @(posedge clk_in);
            end
            // lines no longer meaningful, so show something different
            sa_valid_out <= 1'b0;
            sa_bits_out <= ~sa_bits_out;
            busy_out <= 1'b0;
         end
      end
   end
endmodule // frs_line_model

// [frs_regs_bench.sv]
// self-checking bench for the receive status and overhead register bank
// assumes frs_pkg, frs_regs, frs_line_model and frs_regs_asserts are compiled first
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("BAD %0t got %h want %h", $time, g, e); end end
module frs_regs_bench;
   logic              clk_in, rst_n_in, cs_in, rd_in, wr_in, rd_ack_out, start, busy;
   logic [11:0]       addr_in;
   logic [7:0]        wdata_in, rdata_out, got;
   logic              ds1_mode_in, crc4_on_in, basic_frame_align_in, crc4_mf_align_in;
   logic              sig_mf_align_in, loss_frame_align_in, loss_sig_sf_align_in;
   logic              ts0_signaling_mode_in, alt_cas_mode_a_in, alt_cas_mode_b_in;
   logic              remote_nt_bursty_seconds_in, remote_nt_severe_seconds_in;
   logic              remote_nt_unavail_seconds_in, ts0_valid_in, ts16_valid_in;
   logic              lc_valid_in, perf_valid_in, sa_valid_in, sig_valid_in;
   logic [2:0]        ts16_spare_in;
   logic [4:0]        sa_frame_in, sa_bits_in;
   logic [15:0]       tx_perf_report_byte_in;
   logic [79:0]       pattern;
   frs_pkg::frs_ts0_t ts0_in;
   frs_pkg::frs_lc_t  lc_in;
   frs_pkg::frs_sig_t sig_in;
   int                failures, samples_checked, cycles;
   localparam logic [7:0] LC_EXP [10] = '{8'h07, 8'h07, 8'hb4, 8'hab, 8'h53, 8'h00, 8'h00, 8'h00,
                                          8'hc3, 8'h5a};
   localparam logic [7:0] GF_EXP [4] = '{8'h8f, 8'ha3, 8'hc0, 8'he1};

   frs_regs frs_regs_inst (.*);
   frs_line_model frs_line_model_inst (.clk_in(clk_in), .start_in(start), .pattern_in(pattern),
      .busy_out(busy), .sa_valid_out(sa_valid_in), .sa_frame_out(sa_frame_in),
      .sa_bits_out(sa_bits_in));

   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   // ==========================================================
   // bus and strobe helpers
   task automatic ck(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk_in);
      cs_in <= 1'b1;
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      cs_in <= 1'b0;
      rd_in <= 1'b0;
      got = 8'hxx;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         #1;
         if (rd_ack_out === 1'b1) begin
            got = rdata_out;
            break;
         end
      end
      `CHK(got, e)
   endtask
   task automatic sg(input logic [12:0] v);
      @(posedge clk_in);
      sig_valid_in <= 1'b1;
      sig_in <= frs_pkg::frs_sig_t'(v);
      @(posedge clk_in);
      sig_valid_in <= 1'b0;
   endtask
   task automatic send(input logic [79:0] p, input logic [79:0] e);
      @(posedge clk_in);
      pattern <= p;
      start <= 1'b1;
      @(posedge clk_in);
      start <= 1'b0;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk_in);
         #1;
         if (busy === 1'b0) break;
      end
      for (int i = 0; i < 10; i++) ck(frs_pkg::FRS_STACK_OFS + 12'(i), e[79 - 8 * i -: 8]);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_count;
      for (int i = 0; i < 8; i++) ck(frs_pkg::FRS_BURSTY_OFS + 12'(i), 8'h00);
      ck(12'h0600, 8'h00);
      for (int i = 0; i < 258; i++) begin
         @(posedge clk_in);
         remote_nt_bursty_seconds_in <= (i < 3);
         remote_nt_severe_seconds_in <= 1'b1;
         remote_nt_unavail_seconds_in <= (i == 0);
      end
      @(posedge clk_in);
      remote_nt_bursty_seconds_in <= 1'b0;
      remote_nt_severe_seconds_in <= 1'b0;
      ck(12'h062e, 8'h00);
      ck(12'h062f, 8'h03);
      ck(12'h0630, 8'h01);
      ck(12'h0631, 8'h02);
      ck(12'h0633, 8'h01);
   endtask
   task automatic t_overhead;
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_in);
         basic_frame_align_in <= (i == 0);
         sig_mf_align_in <= (i == 0);
         ts0_valid_in <= 1'b1;
         ts0_in <= frs_pkg::frs_ts0_t'(i == 0 ? 8'h96 : 8'h3c);
         ts16_valid_in <= 1'b1;
         ts16_spare_in <= (i == 0) ? 3'b101 : 3'b010;
         @(posedge clk_in);
         ts0_valid_in <= 1'b0;
         ts16_valid_in <= 1'b0;
         ck(frs_pkg::FRS_TS0_OFS, 8'h96);
         ck(frs_pkg::FRS_TS16_OFS, 8'h05);
      end
      @(posedge clk_in);
      cs_in <= 1'b1;
      wr_in <= 1'b1;
      addr_in <= frs_pkg::FRS_TS0_OFS;
      wdata_in <= 8'hff;
      @(posedge clk_in);
      cs_in <= 1'b0;
      wr_in <= 1'b0;
      ck(frs_pkg::FRS_TS0_OFS, 8'h96);
   endtask
   task automatic t_loop_carrier;
      ds1_mode_in <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_in);
         loss_sig_sf_align_in <= (i == 1);
         loss_frame_align_in <= (i == 2);
         lc_valid_in <= 1'b1;
         lc_in <= (i == 0) ? {11'h5a5, 4'b0101, 3'b110, 2'b10, 4'b1001} : 24'h0000_00;
         perf_valid_in <= (i == 0);
         tx_perf_report_byte_in <= 16'hc35a;
         @(posedge clk_in);
         lc_valid_in <= 1'b0;
         perf_valid_in <= 1'b0;
         ck(12'h063e, 8'hc3);
         for (int k = 0; k < 10; k++) ck(frs_pkg::FRS_STACK_OFS + 12'(k), LC_EXP[k]);
      end
      loss_sig_sf_align_in <= 1'b0;
      loss_frame_align_in <= 1'b0;
   endtask
   task automatic t_sa;
      ds1_mode_in <= 1'b0;
      crc4_on_in <= 1'b1;
      crc4_mf_align_in <= 1'b1;
      send(80'h0123_4567_89ab_cdef_1357, 80'h0123_4567_89ab_cdef_1357);
      crc4_mf_align_in <= 1'b0;
      basic_frame_align_in <= 1'b1;
      send(80'hfedc_ba98_7654_3210_2468, 80'h0123_4567_89ab_cdef_1357);
      crc4_on_in <= 1'b0;
      send(80'hfedc_ba98_7654_3210_2468, 80'hfedc_ba98_7654_3210_2468);
   endtask
   task automatic t_signaling;
      ds1_mode_in <= 1'b1;
      for (int g = 0; g < 4; g++) begin
         sg({5'(g), 1'b1, 1'b1, 4'hf, 2'(g)});
         ck(frs_pkg::FRS_SIG_OFS + 12'(g), GF_EXP[g]);
      end
      ds1_mode_in <= 1'b0;
      ts0_signaling_mode_in <= 1'b1;
      sg({5'd5, 1'b1, 1'b1, 4'ha, 2'b11});
      ck(12'h0645, 8'h9a);
      sg({5'd16, 1'b0, 1'b1, 4'hf, 2'b00});
      ck(12'h0650, 8'h13);
      sg({5'd0, 1'b0, 1'b1, 4'hf, 2'b00});
      ck(12'h0640, 8'h10);
      alt_cas_mode_a_in <= 1'b1;
      sg({5'd6, 1'b1, 1'b1, 4'ha, 2'b00});
      ck(12'h0646, 8'h8a);
      alt_cas_mode_a_in <= 1'b0;
      alt_cas_mode_b_in <= 1'b1;
      sg({5'd7, 1'b1, 1'b1, 4'ha, 2'b00});
      ck(12'h0647, 8'h8a);
      alt_cas_mode_b_in <= 1'b0;
      ts0_signaling_mode_in <= 1'b0;
      sg({5'd16, 1'b0, 1'b1, 4'hf, 2'b00});
      ck(12'h0650, 8'h00);
   endtask
   // ==========================================================
   // verdict and hang guard
   task automatic close_out;
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         $display("BAD %0t run too long", $time);
         close_out();
      end
   end
   initial begin
      {rst_n_in, cs_in, rd_in, wr_in, addr_in, wdata_in, ds1_mode_in, crc4_on_in} = '0;
      {basic_frame_align_in, crc4_mf_align_in, sig_mf_align_in, loss_frame_align_in} = '0;
      {loss_sig_sf_align_in, ts0_signaling_mode_in, alt_cas_mode_a_in, alt_cas_mode_b_in} = '0;
      {remote_nt_bursty_seconds_in, remote_nt_severe_seconds_in, remote_nt_unavail_seconds_in} = '0;
      {ts0_valid_in, ts0_in, ts16_valid_in, ts16_spare_in, lc_valid_in, lc_in} = '0;
      {perf_valid_in, tx_perf_report_byte_in, sig_valid_in, sig_in, start, pattern} = '0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_count();
      t_overhead();
      t_loop_carrier();
      t_sa();
      t_signaling();
      close_out();
   end
endmodule // frs_regs_bench

bind frs_regs frs_regs_asserts frs_regs_asserts_inst (.*);
